// ===== rtl/stx_exec.sv
/*
  Execution unit for nibble exchange, null skips, bit-test skip, table fetches
  and the three exclusive-OR forms of an 8-bit core.
  Assumes a decoder presents one operation per cycle with opValid, along with
  the addressed memory byte, immediate and bit select; the program store
  answers a table read on progWord in the same cycle; progAddr shows the address a cycle later.
*/
`timescale 1ns/10ps
`include "stx_defines.svh"

module stx_exec #(
  parameter int DW = `STX_DATA_W,
  parameter int WW = `STX_WORD_W,
  parameter int PW = `STX_PC_W
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            opValid,
  input  wire stx_pkg::stx_op_t opCode,
  input  wire logic [DW-1:0]   memRdData,
  input  wire logic [DW-1:0]   immData,
  input  wire logic [2:0]      bitSel,
  input  wire logic [DW-1:0]   tablePointer,
  input  wire logic [PW-1:0]   fetchPc,
  input  wire logic [WW-1:0]   progWord,
  output logic      [PW-1:0]   progAddr,
  output logic      [DW-1:0]   workingRegister,
  output logic      [DW-1:0]   tableUpperByte,
  output logic                 zeroFlag,
  output logic                 memWrEn,
  output logic      [DW-1:0]   memWrData,
  output logic                 discardFetch,
  output logic                 busy
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  stx_pkg::stx_state_t state_reg, state_next;
  logic [DW-1:0]       work_reg, work_next;
  logic [DW-1:0]       tblHi_reg, tblHi_next;
  logic                zero_reg, zero_next;
  logic                wrEn_reg;
  logic [DW-1:0]       wrData_reg;
  logic                discard_reg;
  logic                busy_reg;
  logic [PW-1:0]       progAddr_reg;

  // ----------------------------------------
  // Result path
  // ----------------------------------------
  wire logic [DW-1:0] nibbleSwapped;
  wire logic [DW-1:0] xorMem;
  wire logic [DW-1:0] xorImm;
  wire logic          memIsNull;
  wire logic          bitIsNull;
  wire logic          xorMemNull;
  wire logic          xorImmNull;

  stx_result_unit #(.DW(DW)) uResult (
    .memByte       (memRdData),
    .workByte      (work_reg),
    .immByte       (immData),
    .bitSel        (bitSel),
    .nibbleSwapped (nibbleSwapped),
    .xorMem        (xorMem),
    .xorImm        (xorImm),
    .memIsNull     (memIsNull),
    .bitIsNull     (bitIsNull),
    .xorMemNull    (xorMemNull),
    .xorImmNull    (xorImmNull)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // One compare per operation; a dead phase masks every match at once
  function automatic logic opHit(
    input logic             live,
    input stx_pkg::stx_op_t code,
    input stx_pkg::stx_op_t want
  );
    opHit = live && (code == want);
  endfunction : opHit

  // Operations arriving during the dummy cycle belong to the discarded fetch
  wire logic run     = opValid && (state_reg == stx_pkg::STX_ST_RUN);
  wire logic isNibX  = opHit(run, opCode, stx_pkg::STX_OP_NIBX);
  wire logic isSkipN = opHit(run, opCode, stx_pkg::STX_OP_SKIP_NULL);
  wire logic isCopyS = opHit(run, opCode, stx_pkg::STX_OP_COPY_SKIP);
  wire logic isBitS  = opHit(run, opCode, stx_pkg::STX_OP_BIT_SKIP);
  wire logic isTblC  = opHit(run, opCode, stx_pkg::STX_OP_TBL_CUR);
  wire logic isTblF  = opHit(run, opCode, stx_pkg::STX_OP_TBL_FIN);
  wire logic isXorW  = opHit(run, opCode, stx_pkg::STX_OP_XOR_W);
  wire logic isXorM  = opHit(run, opCode, stx_pkg::STX_OP_XOR_M);
  wire logic isXorI  = opHit(run, opCode, stx_pkg::STX_OP_XOR_IMM);
  wire logic isTbl   = isTblC || isTblF;

  wire logic skipTaken = ((isSkipN || isCopyS) && memIsNull)
                       || (isBitS && bitIsNull);

  // Page bits come from the fetch counter or are forced to the last page
  wire logic [`STX_PAGE_W-1:0] tblPage = isTblF ? `STX_LAST_PAGE
                                                : fetchPc[`STX_PAGE_HI];
  wire logic [PW-1:0] tblAddr = {tblPage, tablePointer};

  // ----------------------------------------
  // Next-state selection
  // ----------------------------------------
  always_comb
  begin
    state_next = skipTaken ? stx_pkg::STX_ST_DUMMY : stx_pkg::STX_ST_RUN;
    work_next  = work_reg;
    tblHi_next = tblHi_reg;
    zero_next  = zero_reg;
    case (1'b1)
      isNibX:  work_next = nibbleSwapped;
      isCopyS: work_next = memRdData;
      isTbl:   tblHi_next = progWord[`STX_BYTE_HI];
      isXorW:
      begin
        work_next = xorMem;
        zero_next = xorMemNull;
      end
      isXorM:  zero_next = xorMemNull;
      isXorI:
      begin
        work_next = xorImm;
        zero_next = xorImmNull;
      end
      default: work_next = work_reg;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= stx_pkg::STX_ST_RUN;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      work_reg <= `STX_RST_BYTE;
    else
      work_reg <= work_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tblHi_reg <= `STX_RST_BYTE;
    else
      tblHi_reg <= tblHi_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      zero_reg <= `STX_RST_FLAG;
    else
      zero_reg <= zero_next;
  end

  // Memory write, discard strobe and table address are registered so that
  // every output comes from a flip-flop; the memory side sees them a cycle late.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wrEn_reg <= `STX_RST_FLAG;
    else
      wrEn_reg <= isXorM || isTbl;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wrData_reg <= `STX_RST_BYTE;
    else
      wrData_reg <= isTbl ? progWord[`STX_BYTE_LO] : xorMem;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      discard_reg <= `STX_RST_FLAG;
    else
      discard_reg <= skipTaken;
  end

  // Own flop for the pin rather than a decode of the phase register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_reg <= `STX_RST_FLAG;
    else
      busy_reg <= skipTaken;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      progAddr_reg <= '0;
    else
      progAddr_reg <= tblAddr;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign workingRegister = work_reg;
  assign tableUpperByte  = tblHi_reg;
  assign zeroFlag        = zero_reg;
  assign memWrEn         = wrEn_reg;
  assign memWrData       = wrData_reg;
  assign discardFetch    = discard_reg;
  assign busy            = busy_reg;
  assign progAddr        = progAddr_reg;

endmodule : stx_exec

// ===== rtl/stx_defines.svh
/*
  Constants for the skip, table-fetch and exclusive-OR execution unit.
  Assumes an 8-bit data path, 16-bit program words and a 13-bit program counter.
*/
`ifndef STX_DEFINES_SVH
`define STX_DEFINES_SVH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define STX_DATA_W      8
`define STX_WORD_W      16
`define STX_PC_W        13
`define STX_NIB_LO      3:0
`define STX_NIB_HI      7:4
`define STX_BYTE_LO     7:0
`define STX_BYTE_HI     15:8
`define STX_PAGE_HI     12:8
`define STX_PAGE_W      5
`define STX_RST_FLAG    1'b0
`define STX_LAST_PAGE   5'h1f
`define STX_ZERO_BYTE   8'h00
`define STX_RST_BYTE    8'h00

`endif

// ===== rtl/stx_pkg.sv
/*
  Types for the skip, table-fetch and exclusive-OR execution unit.
  Assumes stx_defines.svh is compiled alongside.
*/
package stx_pkg;

  // ----------------------------------------
  // Operation codes handed in by the decoder
  // ----------------------------------------
  typedef enum logic [3:0]
  {
    STX_OP_NONE      = 4'b0000,
    STX_OP_NIBX      = 4'b0001,
    STX_OP_SKIP_NULL = 4'b0010,
    STX_OP_COPY_SKIP = 4'b0011,
    STX_OP_BIT_SKIP  = 4'b0100,
    STX_OP_TBL_CUR   = 4'b0101,
    STX_OP_TBL_FIN   = 4'b0110,
    STX_OP_XOR_W     = 4'b0111,
    STX_OP_XOR_M     = 4'b1000,
    STX_OP_XOR_IMM   = 4'b1001
  } stx_op_t;

  // ----------------------------------------
  // Execution phase
  // ----------------------------------------
  typedef enum logic [0:0]
  {
    STX_ST_RUN   = 1'b0,
    STX_ST_DUMMY = 1'b1
  } stx_state_t;

endpackage : stx_pkg

// ===== rtl/stx_result_unit.sv
/*
  Combinational result path: nibble exchange, exclusive-OR and zero tests.
  Assumes operands are stable for the whole instruction cycle.
*/
`timescale 1ns/10ps
`include "stx_defines.svh"

module stx_result_unit #(
  parameter int DW = `STX_DATA_W
) (
  input  wire logic [DW-1:0] memByte,
  input  wire logic [DW-1:0] workByte,
  input  wire logic [DW-1:0] immByte,
  input  wire logic [2:0]    bitSel,
  output logic      [DW-1:0] nibbleSwapped,
  output logic      [DW-1:0] xorMem,
  output logic      [DW-1:0] xorImm,
  output logic               memIsNull,
  output logic               bitIsNull,
  output logic               xorMemNull,
  output logic               xorImmNull
);

  function automatic logic isNull(input logic [DW-1:0] v);
    isNull = (v == `STX_ZERO_BYTE);
  endfunction : isNull

  assign nibbleSwapped = {memByte[`STX_NIB_LO], memByte[`STX_NIB_HI]};
  assign xorMem        = workByte ^ memByte;
  assign xorImm        = workByte ^ immByte;
  assign memIsNull     = isNull(memByte);
  assign bitIsNull     = ~memByte[bitSel];
  assign xorMemNull    = isNull(xorMem);
  assign xorImmNull    = isNull(xorImm);

endmodule : stx_result_unit

// ===== testbench/stx_exec_chk.sv
/* Port checker for stx_exec.
   Bound to every stx_exec instance; one clock domain. */
`timescale 1ns/10ps
module stx_exec_chk #(
  parameter int DW = 8,
  parameter int WW = 16,
  parameter int PW = 13
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             opValid,
  input wire stx_pkg::stx_op_t opCode,
  input wire logic [DW-1:0]    memRdData,
  input wire logic [DW-1:0]    immData,
  input wire logic [2:0]       bitSel,
  input wire logic [DW-1:0]    tablePointer,
  input wire logic [PW-1:0]    fetchPc,
  input wire logic [WW-1:0]    progWord,
  input wire logic [PW-1:0]    progAddr,
  input wire logic [DW-1:0]    workingRegister,
  input wire logic [DW-1:0]    tableUpperByte,
  input wire logic             zeroFlag,
  input wire logic             memWrEn,
  input wire logic [DW-1:0]    memWrData,
  input wire logic             discardFetch,
  input wire logic             busy
);
  // ----
  // Operand views sampled one cycle back
  // ----
  wire          take   = opValid && !busy;
  wire          isNull = memRdData == '0;
  wire          selBit = memRdData[bitSel];
  wire [DW-1:0] swp    = {memRdData[3:0], memRdData[7:4]};
  wire [DW-1:0] xw     = workingRegister ^ memRdData;
  wire [DW-1:0] xi     = workingRegister ^ immData;
  wire [PW-1:0] curA   = {fetchPc[PW-1:8], tablePointer};
  wire [PW-1:0] finA   = {5'h1f, tablePointer};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_nib_swap: assert property (take && opCode == stx_pkg::STX_OP_NIBX |=>
    workingRegister == $past(swp) && $stable(zeroFlag) && !memWrEn) else $error("nibble");
  a_skip_null: assert property (take && opCode == stx_pkg::STX_OP_SKIP_NULL |=>
    discardFetch == $past(isNull) && busy == $past(isNull) && $stable(zeroFlag))
    else $error("skip null");
  a_dummy_one: assert property (busy |=> !busy && !discardFetch && $stable(workingRegister))
    else $error("dummy cycle");
  a_copy_skip: assert property (take && opCode == stx_pkg::STX_OP_COPY_SKIP |=>
    workingRegister == $past(memRdData) && busy == $past(isNull) && $stable(zeroFlag))
    else $error("copy skip");
  a_bit_skip: assert property (take && opCode == stx_pkg::STX_OP_BIT_SKIP |=>
    discardFetch == !$past(selBit) && busy == !$past(selBit)) else $error("bit skip");
  a_tbl_cur: assert property (take && opCode == stx_pkg::STX_OP_TBL_CUR |=> memWrEn &&
    {tableUpperByte, memWrData} == $past(progWord) && progAddr == $past(curA))
    else $error("table current");
  a_tbl_fin: assert property (take && opCode == stx_pkg::STX_OP_TBL_FIN |=> memWrEn &&
    {tableUpperByte, memWrData} == $past(progWord) && progAddr == $past(finA))
    else $error("table final");
  a_xor_w: assert property (take && opCode == stx_pkg::STX_OP_XOR_W |=>
    workingRegister == $past(xw) && zeroFlag == ($past(xw) == '0)) else $error("xor w");
  a_xor_m: assert property (take && opCode == stx_pkg::STX_OP_XOR_M |=> memWrEn &&
    memWrData == $past(xw) && zeroFlag == ($past(xw) == '0)) else $error("xor m");
  a_xor_imm: assert property (take && opCode == stx_pkg::STX_OP_XOR_IMM |=>
    workingRegister == $past(xi) && zeroFlag == ($past(xi) == '0)) else $error("xor imm");
endmodule : stx_exec_chk
bind stx_exec stx_exec_chk #(.DW(DW), .WW(WW), .PW(PW)) i_chk (.clk(clk), .rst_n(rst_n),
  .opValid(opValid), .opCode(opCode), .memRdData(memRdData), .immData(immData),
  .bitSel(bitSel), .tablePointer(tablePointer), .fetchPc(fetchPc), .progWord(progWord),
  .progAddr(progAddr), .workingRegister(workingRegister), .tableUpperByte(tableUpperByte),
  .zeroFlag(zeroFlag), .memWrEn(memWrEn), .memWrData(memWrData),
  .discardFetch(discardFetch), .busy(busy));

// ===== testbench/tb_top.sv
/* Self-checking bench for stx_exec.
   Acts as decoder and program store; inputs change on falling edges. */
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_top;
  logic clk, rst_n, opValid, zeroFlag, memWrEn, discardFetch, busy;
  stx_pkg::stx_op_t opCode;
  logic [7:0]  memRdData, immData, tablePointer, workingRegister, tableUpperByte, memWrData;
  logic [2:0]  bitSel;
  logic [12:0] fetchPc, progAddr;
  logic [15:0] progWord;
  int          err_total, n_tests, cyc;
  // ----
  // Program store, answers in the same cycle
  // ----
  function automatic logic [15:0] rom(input logic [12:0] a);
    return {a[7:0] ^ 8'h5a, 3'h0, a[12:8]};
  endfunction : rom
  assign progWord = rom(opCode == stx_pkg::STX_OP_TBL_FIN ? {5'h1f, tablePointer}
                                                          : {fetchPc[12:8], tablePointer});
  stx_exec i_dut (.clk(clk), .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
    .memRdData(memRdData), .immData(immData), .bitSel(bitSel), .tablePointer(tablePointer),
    .fetchPc(fetchPc), .progWord(progWord), .progAddr(progAddr),
    .workingRegister(workingRegister), .tableUpperByte(tableUpperByte), .zeroFlag(zeroFlag),
    .memWrEn(memWrEn), .memWrData(memWrData), .discardFetch(discardFetch), .busy(busy));
  // Valid stays up between ops; only dummy cycles see a stale op, which is ignored
  task automatic issue(input stx_pkg::stx_op_t op, input logic [7:0] m, input logic [7:0] x);
    opValid = 1'b1;
    opCode = op;
    memRdData = m;
    immData = x;
    @(negedge clk);
  endtask : issue
  task automatic t_xor;
    issue(stx_pkg::STX_OP_XOR_IMM, 8'h00, 8'h3c);
    `CHK("w z", 9'h078, {workingRegister, zeroFlag})
    issue(stx_pkg::STX_OP_XOR_W, 8'h3c, 8'h00);
    `CHK("w z", 9'h001, {workingRegister, zeroFlag})
    issue(stx_pkg::STX_OP_XOR_M, 8'ha5, 8'h00);
    `CHK("wr z w", 18'h34a00, {memWrEn, memWrData, zeroFlag, workingRegister})
    issue(stx_pkg::STX_OP_XOR_IMM, 8'h00, 8'h00);
    `CHK("w z", 9'h001, {workingRegister, zeroFlag})
    $display("xor test end");
  endtask : t_xor
  task automatic t_nib;
    issue(stx_pkg::STX_OP_NIBX, 8'ha5, 8'h00);
    `CHK("w z wr", 10'h16a, {workingRegister, zeroFlag, memWrEn})
    $display("nibble test end");
  endtask : t_nib
  task automatic t_skip;
    issue(stx_pkg::STX_OP_SKIP_NULL, 8'h00, 8'h00);
    `CHK("skip", 2'b11, {discardFetch, busy})
    issue(stx_pkg::STX_OP_XOR_IMM, 8'h00, 8'hff);
    `CHK("w busy", 9'h0b4, {workingRegister, busy})
    issue(stx_pkg::STX_OP_SKIP_NULL, 8'h01, 8'h00);
    `CHK("no skip", 2'b00, {discardFetch, busy})
    issue(stx_pkg::STX_OP_COPY_SKIP, 8'h00, 8'h00);
    `CHK("copy", 10'h003, {workingRegister, discardFetch, zeroFlag})
    @(negedge clk);
    issue(stx_pkg::STX_OP_COPY_SKIP, 8'h80, 8'h00);
    `CHK("copy", 9'h100, {workingRegister, discardFetch})
    $display("skip test end");
  endtask : t_skip
  task automatic t_bit;
    for (int b = 0; b < 8; b++)
    begin
      bitSel = b[2:0];
      issue(stx_pkg::STX_OP_BIT_SKIP, 8'h01 << b, 8'h00);
      `CHK("bit one", 1'b0, discardFetch)
      issue(stx_pkg::STX_OP_BIT_SKIP, ~(8'h01 << b), 8'h00);
      `CHK("bit zero", 1'b1, discardFetch)
      @(negedge clk);
    end
    $display("bit test end");
  endtask : t_bit
  task automatic t_tbl;
    tablePointer = 8'h34;
    fetchPc = 13'h0a12;
    issue(stx_pkg::STX_OP_TBL_CUR, 8'h00, 8'h00);
    `CHK("tbl", {1'b1, rom(13'h0a34), 13'h0a34}, {memWrEn, tableUpperByte, memWrData, progAddr})
    issue(stx_pkg::STX_OP_TBL_FIN, 8'h00, 8'h00);
    `CHK("tbl", {1'b1, rom(13'h1f34), 13'h1f34}, {memWrEn, tableUpperByte, memWrData, progAddr})
    $display("table test end");
  endtask : t_tbl
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Ceiling well above the forty or so cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    {rst_n, opValid, memRdData, immData, bitSel, tablePointer, fetchPc} = '0;
    opCode = stx_pkg::STX_OP_NONE;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_xor();
    t_nib();
    t_skip();
    t_bit();
    t_tbl();
    results();
  end
endmodule : tb_top
